// >>> inc/asb_pkg.sv
// Purpose: Constants and types for the acceleration sample buffer
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Depth is a power of two so pointers wrap on their own
`default_nettype none
package asb_pkg;
    localparam int unsigned DEPTH = 32;
    localparam int unsigned PTR_W = 5;
    localparam int unsigned CNT_W = 6;
    localparam int unsigned SMP_W = 48;
    localparam logic [CNT_W-1:0] FULL_COUNT = 6'h20;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam logic [7:0] OFS_INT_STAT = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;
    // Field positions
    localparam int unsigned CTRL_RES_BIT = 2;
    localparam int unsigned CTRL_CLR_BIT = 8;
    localparam int unsigned ST_TRIG_BIT = 8;
    localparam int unsigned ST_FULL_BIT = 9;
    localparam int unsigned ST_WM_BIT = 10;
    localparam int unsigned ST_BEYOND_POS = 16;
    localparam int unsigned INT_WM_BIT = 0;
    localparam int unsigned INT_FULL_BIT = 1;
    localparam int unsigned INT_TRIG_BIT = 2;
    // Reset values
    localparam logic [6:0] THRESH_RESET = 7'h00;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;
    // Bytes per sample at each resolution
    localparam logic [2:0] BYTES_LOW = 3'h3;
    localparam logic [2:0] BYTES_HIGH = 3'h6;

    typedef enum logic [1:0] {
        ASB_MODE_FIFO = 2'h0,
        ASB_MODE_STREAM = 2'h1,
        ASB_MODE_TRIGGER = 2'h3,
        ASB_MODE_LIFO = 2'h2
    } asb_mode_t;
endpackage
`default_nettype wire

// >>> inc/asb_mem_if.sv
// Purpose: Carrier between buffer control and sample storage
// Assumes: One write port and one registered read port
// Notes: Read data lags the read address by one clock
`timescale 1ns/100ps
`default_nettype none
interface asb_mem_if;
    logic we;
    logic [asb_pkg::PTR_W-1:0] waddr;
    logic [asb_pkg::SMP_W-1:0] wdata;
    logic [asb_pkg::PTR_W-1:0] raddr;
    logic [asb_pkg::SMP_W-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> hw/asb_sample_mem.sv
// Purpose: Sample storage, one word per three-axis sample
// Assumes: Single clock, read data registered
// Notes: Contents are not reset; pointers define what is valid
`timescale 1ns/100ps
`default_nettype none
module asb_sample_mem (
    // Clock
    input wire logic i_sys_clk,
    // Storage port
    asb_mem_if.mem mem
);
    logic [asb_pkg::SMP_W-1:0] store [asb_pkg::DEPTH];
    logic [asb_pkg::SMP_W-1:0] rdata_q;

    // Write and registered read
    always_ff @(posedge i_sys_clk) begin
        if (mem.we) begin
            store[mem.waddr] <= mem.wdata;
        end
        rdata_q <= store[mem.raddr];
    end

    assign mem.rdata = rdata_q;
endmodule
`default_nettype wire

// >>> hw/asb_top.sv
// Purpose: Acceleration sample buffer with four modes behind APB
// Assumes: One sample strobe per output data period, trigger pulse
// Notes on behaviour
// - After trigger, stop discarding; append until full
// - Trigger fill done halts collection, keeps history
// - Keep storing past threshold until capacity
// - FIFO and post-event trigger: full buffer refuses samples
// - Stream and LIFO: full drops oldest per sample
// - Non-LIFO read removes oldest sample
// - LIFO read removes newest sample
// - Watermark while count at or above threshold, except in trigger mode
// - Trigger mode pre-event: at threshold drop oldest
// - Samples stored at selected resolution
`timescale 1ns/100ps
`default_nettype none
module asb_top (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Sample input
    input wire logic i_sample_valid,
    input wire logic [11:0] i_sample_x,
    input wire logic [11:0] i_sample_y,
    input wire logic [11:0] i_sample_z,
    input wire logic i_trigger,
    // Interrupt
    output logic o_irq
);
    typedef struct packed {
        asb_pkg::asb_mode_t mode;
        logic res;
        logic [6:0] thresh;
        logic [asb_pkg::PTR_W-1:0] rd_ptr;
        logic [asb_pkg::PTR_W-1:0] wr_ptr;
        logic [asb_pkg::CNT_W-1:0] count;
        logic trig_seen;
        logic [2:0] byte_idx;
        logic wait_q;
        logic pend;
        logic [asb_pkg::SMP_W-1:0] pend_word;
        logic [2:0] int_stat;
        logic [2:0] int_mask;
        logic wm_last;
        logic full_last;
        logic trig_last;
        logic [31:0] prdata;
        logic slverr;
    } asb_state_t;

    asb_state_t state_q;
    asb_state_t state_d;
    asb_mem_if mem_bus ();

    // Storage
    asb_sample_mem u_mem (
        .i_sys_clk(i_sys_clk),
        .mem(mem_bus)
    );

    // Pack a sample, low resolution keeps only the upper 8 bits
    function automatic logic [asb_pkg::SMP_W-1:0] pack_sample(
        input logic res, input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        logic [3:0] m;
        m = res ? 4'hF : 4'h0;
        return {z[11:4], z[3:0] & m, 4'h0, y[11:4], y[3:0] & m, 4'h0,
            x[11:4], x[3:0] & m, 4'h0};
    endfunction

    // Pick a byte; word bytes are X_L X_H Y_L Y_H Z_L Z_H from bit 0
    function automatic logic [7:0] pick_byte(
        input logic [asb_pkg::SMP_W-1:0] w, input logic res, input logic [2:0] idx);
        logic [2:0] slot;
        slot = res ? idx : 3'(({1'b0, idx[1:0]} << 1) + 3'h1);
        return w[8*slot +: 8];
    endfunction

    // Bytes in one sample at the chosen resolution
    function automatic logic [2:0] sample_bytes(input logic res);
        return res ? asb_pkg::BYTES_HIGH : asb_pkg::BYTES_LOW;
    endfunction

    // Pointer step back by one
    function automatic logic [asb_pkg::PTR_W-1:0] ptr_dec(input logic [asb_pkg::PTR_W-1:0] p);
        return p - 1'b1;
    endfunction

    logic acc_first;
    logic acc_done;
    logic data_sel;
    logic lifo;
    logic full;
    logic at_thresh;
    logic watermark;
    logic trig_flag;
    logic take;
    logic [asb_pkg::SMP_W-1:0] take_word;
    logic [2:0] nbytes;
    logic [2:0] sel_idx;
    logic [6:0] cnt_ext;
    logic [asb_pkg::CNT_W-1:0] beyond;

    // Decoded conditions from current state
    always_comb begin
        acc_first = i_psel & i_penable & ~state_q.wait_q;
        acc_done = i_psel & i_penable & state_q.wait_q;
        data_sel = i_psel & (i_paddr == asb_pkg::OFS_DATA);
        lifo = state_q.mode == asb_pkg::ASB_MODE_LIFO;
        full = state_q.count == asb_pkg::FULL_COUNT;
        // Count widened to the threshold field so large thresholds never fold
        cnt_ext = {1'b0, state_q.count};
        at_thresh = cnt_ext >= state_q.thresh;
        watermark = at_thresh && (state_q.mode != asb_pkg::ASB_MODE_TRIGGER);
        trig_flag = state_q.trig_seen && at_thresh;
        beyond = at_thresh ? asb_pkg::CNT_W'(cnt_ext - state_q.thresh) : '0;
        nbytes = sample_bytes(state_q.res);
        sel_idx = lifo ? 3'(nbytes - 3'h1 - state_q.byte_idx) : state_q.byte_idx;
        take = i_sample_valid | state_q.pend;
        take_word = i_sample_valid ?
            pack_sample(state_q.res, i_sample_x, i_sample_y, i_sample_z) :
            state_q.pend_word;
    end

    // Next state
    always_comb begin
        logic push;
        logic drop;
        push = 1'b0;
        drop = 1'b0;
        state_d = state_q;
        mem_bus.we = 1'b0;
        mem_bus.waddr = state_q.wr_ptr;
        mem_bus.wdata = take_word;
        mem_bus.raddr = lifo ? ptr_dec(state_q.wr_ptr) : state_q.rd_ptr;

        // Sample intake, deferred while the data register is selected on the bus, read or write
        // A sample arriving while one is pending replaces it
        if (take && data_sel) begin
            state_d.pend = 1'b1;
            state_d.pend_word = take_word;
        end else if (take) begin
            state_d.pend = 1'b0;
            unique case (state_q.mode)
                asb_pkg::ASB_MODE_FIFO: begin
                    push = ~full;
                end
                asb_pkg::ASB_MODE_STREAM, asb_pkg::ASB_MODE_LIFO: begin
                    push = 1'b1;
                    drop = full;
                end
                asb_pkg::ASB_MODE_TRIGGER: begin
                    if (state_q.trig_seen) begin
                        push = ~full;
                    end else begin
                        push = 1'b1;
                        // A full buffer drops too, whatever the threshold
                        drop = at_thresh | full;
                    end
                end
            endcase
        end
        if (push) begin
            mem_bus.we = 1'b1;
            state_d.wr_ptr = state_q.wr_ptr + 1'b1;
            if (drop) begin
                state_d.rd_ptr = state_q.rd_ptr + 1'b1;
            end else begin
                state_d.count = state_q.count + 1'b1;
            end
        end

        // APB: setup, then two access cycles; read data latched in the first
        state_d.wait_q = acc_first;
        if (acc_first) begin
            state_d.slverr = 1'b0;
            state_d.prdata = '0;
            unique case (i_paddr)
                asb_pkg::OFS_CTRL: begin
                    state_d.prdata = {29'h0, state_q.res, state_q.mode};
                end
                asb_pkg::OFS_THRESH: begin
                    state_d.prdata = {25'h0, state_q.thresh};
                end
                asb_pkg::OFS_STATUS: begin
                    state_d.prdata[asb_pkg::CNT_W-1:0] = state_q.count;
                    state_d.prdata[asb_pkg::ST_TRIG_BIT] = trig_flag;
                    state_d.prdata[asb_pkg::ST_FULL_BIT] = full;
                    state_d.prdata[asb_pkg::ST_WM_BIT] = watermark;
                    state_d.prdata[asb_pkg::ST_BEYOND_POS +: asb_pkg::CNT_W] = beyond;
                end
                asb_pkg::OFS_DATA: begin
                    if (state_q.count != '0) begin
                        state_d.prdata = {24'h0, pick_byte(mem_bus.rdata, state_q.res, sel_idx)};
                    end
                end
                asb_pkg::OFS_INT_STAT: begin
                    state_d.prdata = {29'h0, state_q.int_stat};
                end
                asb_pkg::OFS_INT_MASK: begin
                    state_d.prdata = {29'h0, state_q.int_mask};
                end
                default: begin
                    state_d.slverr = 1'b1;
                end
            endcase
        end

        // Data read completion: pop a sample after its last byte
        if (acc_done && !i_pwrite && i_paddr == asb_pkg::OFS_DATA && state_q.count != '0) begin
            if (state_q.byte_idx == 3'(nbytes - 3'h1)) begin
                state_d.byte_idx = 3'h0;
                state_d.count = state_q.count - 1'b1;
                if (lifo) begin
                    state_d.wr_ptr = ptr_dec(state_q.wr_ptr);
                end else begin
                    state_d.rd_ptr = state_q.rd_ptr + 1'b1;
                end
            end else begin
                state_d.byte_idx = state_q.byte_idx + 3'h1;
            end
        end

        // Register writes
        if (acc_done && i_pwrite) begin
            unique case (i_paddr)
                asb_pkg::OFS_CTRL: begin
                    state_d.mode = asb_pkg::asb_mode_t'(i_pwdata[1:0]);
                    state_d.res = i_pwdata[asb_pkg::CTRL_RES_BIT];
                    state_d.byte_idx = 3'h0;
                    if (i_pwdata[asb_pkg::CTRL_CLR_BIT]) begin
                        state_d.rd_ptr = '0;
                        state_d.wr_ptr = '0;
                        state_d.count = '0;
                        state_d.trig_seen = 1'b0;
                        state_d.pend = 1'b0;
                    end
                end
                asb_pkg::OFS_THRESH: begin
                    state_d.thresh = i_pwdata[6:0];
                end
                asb_pkg::OFS_INT_STAT: begin
                    state_d.int_stat = state_q.int_stat & ~i_pwdata[2:0];
                end
                asb_pkg::OFS_INT_MASK: begin
                    state_d.int_mask = i_pwdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // Trigger capture in trigger mode only; it comes after the
        // register writes so that an event wins over a buffer clear
        if (i_trigger && state_q.mode == asb_pkg::ASB_MODE_TRIGGER) begin
            state_d.trig_seen = 1'b1;
        end

        // Sticky events, set wins over a clear in the same cycle
        state_d.wm_last = watermark;
        state_d.full_last = full;
        state_d.trig_last = trig_flag;
        if (watermark && !state_q.wm_last) begin
            state_d.int_stat[asb_pkg::INT_WM_BIT] = 1'b1;
        end
        if (full && !state_q.full_last) begin
            state_d.int_stat[asb_pkg::INT_FULL_BIT] = 1'b1;
        end
        if (trig_flag && !state_q.trig_last) begin
            state_d.int_stat[asb_pkg::INT_TRIG_BIT] = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_q <= '0;
            state_q.thresh <= asb_pkg::THRESH_RESET;
            state_q.int_mask <= asb_pkg::INT_MASK_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Bus response, read data from the register
    assign o_prdata = state_q.prdata;
    assign o_pslverr = state_q.slverr & o_pready;

    // Ready only in the second access cycle: one wait state
    assign o_pready = i_psel & i_penable & state_q.wait_q;

    // Level interrupt while an unmasked sticky bit is set
    assign o_irq = |(state_q.int_stat & state_q.int_mask);
endmodule
`default_nettype wire

// >>> verif/asb_chk.sv
// Purpose: Bus and reset checks on the sample buffer ports
// Assumes: APB slave with exactly one wait state
// Notes: Bound onto every asb_top instance
`timescale 1ns/100ps
`default_nettype none
module asb_chk (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Interrupt
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Decode of the six mapped words
    logic mapped;
    assign mapped = i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    // Transfer timing and response
    a_no_early_ready: assert property (i_psel && i_penable && !$past(i_penable) |-> !o_pready)
        else $error("ready in first access cycle");
    a_ready_second: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready missing in second access cycle");
    a_err_needs_ready: assert property (o_pslverr |-> o_pready)
        else $error("slave error without ready");
    a_unmapped_err: assert property (o_pready && !mapped |-> o_pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (o_pready && mapped |-> !o_pslverr)
        else $error("mapped access refused");
    a_unmapped_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_rdata_stands: assert property (o_pready |=> $stable(o_prdata))
        else $error("read data changed after transfer");
    a_reset_quiet: assert property ($fell(i_sys_rst) |-> !o_irq && o_prdata == 32'h0)
        else $error("outputs not cleared by reset");
endmodule
bind asb_top asb_chk i_asb_chk (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq)
);
`default_nettype wire

// >>> verif/asb_host.sv
// Purpose: Host model issuing APB transfers to the buffer
// Assumes: Caller serialises transfers
// Notes: Waits for ready with no cycle count of its own
`timescale 1ns/100ps
`default_nettype none
module asb_host (
    // Clock
    input wire logic i_sys_clk,
    // APB master side
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    // Idle bus at time zero
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end
    // Setup, access, hold until ready sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge i_sys_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_sys_clk);
        o_penable <= 1'b1;
        do @(posedge i_sys_clk); while (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the four buffer modes
// Assumes: 40 MHz clock, reset held four cycles
// Notes: Sample n carries n, n+64 and n+128 in the X, Y and Z high bytes
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic sv = 1'b0;
    logic trg = 1'b0;
    logic [11:0] sx = 12'h0, sy = 12'h0, sz = 12'h0;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    asb_top i_asb_top (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sample_valid(sv),
        .i_sample_x(sx), .i_sample_y(sy), .i_sample_z(sz), .i_trigger(trg), .o_irq(irq));
    asb_host i_asb_host (.i_sys_clk(i_sys_clk), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
        .i_pready(pready), .i_pslverr(pslverr));
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_asb_host.xfer(1'b1, a, d, rdv, err);
    endtask
    task automatic rd(input logic [7:0] a);
        i_asb_host.xfer(1'b0, a, 32'h0, rdv, err);
    endtask
    // Back-to-back samples n to n+k-1
    task automatic push(input int n, input int k);
        for (int i = n; i < n + k; i++) begin
            @(posedge i_sys_clk);
            sv <= 1'b1;
            sx <= {i[7:0], 4'hA};
            sy <= {i[7:0] + 8'h40, 4'h5};
            sz <= {i[7:0] + 8'h80, 4'hC};
        end
        @(posedge i_sys_clk);
        sv <= 1'b0;
    endtask
    // Byte k of sample n in oldest-first order
    function automatic logic [7:0] eb(input int n, input int k, input bit hi);
        int ax;
        ax = hi ? k / 2 : k;
        if (hi && k % 2 == 0) eb = ax == 0 ? 8'hA0 : (ax == 1 ? 8'h50 : 8'hC0);
        else eb = 8'(n + 64 * ax);
    endfunction
    // Expected status word
    function automatic logic [31:0] stw(input int c, input int t, input bit tm, input bit tg);
        stw = 32'(c) | (32'(c == 32) << 9) | (32'(!tm && c >= t) << 10) | (32'(tg) << 8);
        if (c >= t) stw |= 32'(c - t) << 16;
    endfunction
    // Read one whole sample through the data port
    task automatic rs(input int n, input bit hi, input bit lifo);
        int nb;
        nb = hi ? 6 : 3;
        for (int i = 0; i < nb; i++) begin
            rd(8'h0C);
            chk(rdv, {24'h0, eb(n, lifo ? nb - 1 - i : i, hi)});
        end
    endtask
    task automatic t_fifo;
        wr(8'h04, 32'h8);
        wr(8'h00, 32'h104);
        push(0, 34);
        rd(8'h08);
        chk(rdv, stw(32, 8, 0, 0));
        rs(0, 1, 0);
        rd(8'h08);
        chk(rdv, stw(31, 8, 0, 0));
    endtask
    task automatic t_stream;
        wr(8'h00, 32'h105);
        push(0, 34);
        rd(8'h08);
        chk(rdv, stw(32, 8, 0, 0));
        rs(2, 1, 0);
    endtask
    task automatic t_lifo;
        wr(8'h00, 32'h102);
        push(0, 33);
        rs(32, 0, 1);
        rs(31, 0, 1);
        rd(8'h08);
        chk(rdv, stw(30, 8, 0, 0));
    endtask
    task automatic t_trig;
        wr(8'h04, 32'h4);
        wr(8'h00, 32'h107);
        wr(8'h10, 32'h7);
        push(0, 10);
        rd(8'h08);
        chk(rdv, stw(4, 4, 1, 0));
        @(posedge i_sys_clk);
        trg <= 1'b1;
        @(posedge i_sys_clk);
        trg <= 1'b0;
        push(10, 30);
        rd(8'h08);
        chk(rdv, stw(32, 4, 1, 1));
        rs(6, 1, 0);
        rd(8'h10);
        chk(rdv, 32'h6);
    endtask
    task automatic t_irq;
        wr(8'h00, 32'h100);
        wr(8'h04, 32'h2);
        wr(8'h10, 32'h7);
        rd(8'h10);
        chk(rdv, 32'h0);
        rd(8'h0C);
        chk(rdv, 32'h0);
        push(0, 2);
        rd(8'h10);
        chk(rdv, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(8'h14, 32'h1);
        @(negedge i_sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h10, 32'h1);
        @(negedge i_sys_clk);
        chk({31'h0, irq}, 32'h0);
        rd(8'h40);
        chk({31'h0, err}, 32'h1);
    endtask
    // Verdict and end of run
    task automatic final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report;
        end
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        t_fifo;
        t_stream;
        t_lifo;
        t_trig;
        t_irq;
        final_report;
    end
endmodule
`default_nettype wire
